// >>> core/wtc_pkg.sv
// Constants, field layouts and types shared by the watchdog control block
package wtc_pkg;
	// Register byte offsets on the AHB-Lite slave
	localparam logic [7:0] WTC_CTRL_OFS = 8'h60;
	localparam logic [7:0] WTC_CAUSE_OFS = 8'h64;
	localparam logic [7:0] WTC_RESTART_OFS = 8'h68;
	localparam logic [7:0] WTC_ISTAT_OFS = 8'h6c;
	localparam logic [7:0] WTC_IMASK_OFS = 8'h70;
	// Offset marker used for addresses outside the map
	localparam logic [7:0] WTC_UNMAPPED_OFS = 8'hff;

	// Control register bit positions
	localparam int WTC_BIT_IRQ_FLAG = 7;
	localparam int WTC_BIT_IRQ_EN = 6;
	localparam int WTC_BIT_SEL_HI = 5;
	localparam int WTC_BIT_UNLOCK = 4;
	localparam int WTC_BIT_RST_EN = 3;
	localparam int WTC_BIT_SEL_LO = 0;
	localparam int WTC_SEL_LO_W = 3;
	// Reset cause register bit position
	localparam int WTC_BIT_WRF = 3;

	// Interrupt status and mask bit positions
	localparam int WTC_EV_TIMEOUT = 0;
	localparam int WTC_EV_SYSRST = 1;
	localparam int WTC_EV_REJECT = 2;
	localparam int WTC_EV_W = 3;

	// Reset values
	localparam logic [3:0] WTC_SEL_RST = 4'h0;
	localparam logic [WTC_EV_W-1:0] WTC_IMASK_RST = 3'h0;

	// Timing counts
	localparam logic [2:0] WTC_UNLOCK_CYCLES = 3'h4;
	localparam logic [4:0] WTC_BASE_EXP = 5'h0b;
	localparam logic [3:0] WTC_SEL_MAX = 4'h9;
	localparam int WTC_CNT_W = 21;

	// Vector table entries
	localparam logic [11:0] WTC_VEC_RESET = 12'h000;
	localparam logic [11:0] WTC_VEC_WDT_IDX = 12'h006;
	localparam logic [11:0] WTC_VEC_WORDS = 12'h001;

	// AHB encodings
	localparam logic [2:0] WTC_HSIZE_WORD = 3'h2;

	typedef enum logic [1:0] {
		WTC_MODE_STOP = 2'b00,
		WTC_MODE_IRQ = 2'b01,
		WTC_MODE_IRQRST = 2'b11,
		WTC_MODE_RST = 2'b10
	} wtc_mode_e;

	typedef enum logic {
		WTC_BUS_IDLE = 1'b0,
		WTC_BUS_RDWAIT = 1'b1
	} wtc_bus_e;

	typedef struct packed {
		logic irq_flag;
		logic irq_en;
		logic [3:0] sel;
		logic rst_en;
	} wtc_ctrl_s;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] ofs;
	} wtc_aph_s;

	localparam wtc_ctrl_s WTC_CTRL_RST = '{irq_flag: 1'b0, irq_en: 1'b0,
		sel: WTC_SEL_RST, rst_en: 1'b0};
endpackage

// >>> core/wtc_top.sv
// Watchdog time-out control with AHB-Lite register access
//
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
module wtc_top
	import wtc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic wdt_osc,
	input wire logic wdt_restart,
	input wire logic vector_enter,
	output logic irq,
	output logic wdt_irq_req,
	output logic sys_reset_req,
	output logic [11:0] vector_addr
);

	// Offset compare shared by every register decode
	function automatic logic ofs_hit(input logic [7:0] ofs, input logic [7:0] target);
		return ofs == target;
	endfunction

	wtc_aph_s aph_q, aph_d;
	wtc_bus_e bus_q, bus_d;
	wtc_ctrl_s ctrl_q, ctrl_d;
	logic [7:0] rd_ofs_q;
	logic [2:0] unlock_cnt_q, unlock_cnt_d;
	logic wrf_q, wrf_d;
	logic [WTC_EV_W-1:0] istat_q, istat_d, imask_q, imask_d, ev_set;
	logic [WTC_CNT_W-1:0] cnt_q, cnt_d, lim_m1;
	logic osc_s1_q, osc_s2_q, osc_s3_q;
	logic [31:0] hrdata_q;
	logic hreadyout_q, irq_q, wdt_irq_q, sys_reset_q;
	logic [11:0] vector_addr_q;

	// Address phase capture; anything outside the low byte is unmapped
	wire take = hready & hsel & htrans[1];
	wire in_map = haddr[31:8] == 24'h000000;
	assign aph_d.valid = take;
	assign aph_d.write = hwrite & (hsize == WTC_HSIZE_WORD);
	assign aph_d.ofs = in_map ? haddr[7:0] : WTC_UNMAPPED_OFS;

	// Write data phase decode
	wire wr_fire = aph_q.valid & aph_q.write;
	wire wr_ctrl = wr_fire & ofs_hit(aph_q.ofs, WTC_CTRL_OFS);
	wire wr_cause = wr_fire & ofs_hit(aph_q.ofs, WTC_CAUSE_OFS);
	wire wr_restart = wr_fire & ofs_hit(aph_q.ofs, WTC_RESTART_OFS);
	wire wr_istat = wr_fire & ofs_hit(aph_q.ofs, WTC_ISTAT_OFS);
	wire wr_imask = wr_fire & ofs_hit(aph_q.ofs, WTC_IMASK_OFS);
	wire [7:0] wd = hwdata[7:0];
	wire rd_take = take & ~hwrite;

	// Read-back of the block's own state
	wire unlock = unlock_cnt_q != 3'h0;
	wire rst_en_eff = ctrl_q.rst_en | wrf_q;
	wire [7:0] ctrl_rd = {ctrl_q.irq_flag, ctrl_q.irq_en, ctrl_q.sel[3], unlock,
		rst_en_eff, ctrl_q.sel[2:0]};
	wire [7:0] cause_rd = 8'(wrf_q) << WTC_BIT_WRF;
	wire [31:0] rd_mux = ofs_hit(rd_ofs_q, WTC_CTRL_OFS) ? {24'h000000, ctrl_rd} :
		ofs_hit(rd_ofs_q, WTC_CAUSE_OFS) ? {24'h000000, cause_rd} :
		ofs_hit(rd_ofs_q, WTC_ISTAT_OFS) ? {29'h00000000, istat_q} :
		ofs_hit(rd_ofs_q, WTC_IMASK_OFS) ? {29'h00000000, imask_q} : 32'h00000000;

	// Operating mode from the two enables
	wtc_mode_e mode;
	assign mode = wtc_mode_e'({rst_en_eff, ctrl_q.irq_en});
	wire running = mode != WTC_MODE_STOP;

	// Oscillator edge from the synchronised pin; stage one feeds stage two only
	wire tick = osc_s2_q & ~osc_s3_q;

	// Reserved select codes run the longest documented period
	wire [3:0] sel_eff = (ctrl_q.sel > WTC_SEL_MAX) ? WTC_SEL_MAX : ctrl_q.sel;
	assign lim_m1 = WTC_CNT_W'((22'h000001 << (WTC_BASE_EXP + 5'(sel_eff))) - 22'h000001);
	wire timeout = tick & running & (cnt_q == lim_m1);

	// Combined mode: a second time-out with the flag still set resets
	wire set_flag = timeout & ctrl_q.irq_en & ~(rst_en_eff & ctrl_q.irq_flag);
	wire sys_rst_fire = timeout & rst_en_eff & (~ctrl_q.irq_en | ctrl_q.irq_flag);
	wire restart = wdt_restart | wr_restart;
	wire ack = vector_enter & wdt_irq_q;

	// Opening write of the timed sequence
	wire open_seq = wr_ctrl & wd[WTC_BIT_UNLOCK] & wd[WTC_BIT_RST_EN];
	wire [3:0] wsel = {wd[WTC_BIT_SEL_HI], wd[WTC_BIT_SEL_LO +: WTC_SEL_LO_W]};
	wire reject = wr_ctrl & ~unlock & (~wd[WTC_BIT_RST_EN] & ctrl_q.rst_en |
		wsel != ctrl_q.sel);

	// Unlock window: loads four, counts down, reads as set while nonzero
	assign unlock_cnt_d = open_seq ? WTC_UNLOCK_CYCLES :
		unlock ? unlock_cnt_q - 3'h1 : 3'h0;

	// Control register next value; hardware set beats the software clear
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d.irq_en = wd[WTC_BIT_IRQ_EN];
			if (unlock) begin
				ctrl_d.rst_en = wd[WTC_BIT_RST_EN];
				ctrl_d.sel = wsel;
			end else begin
				ctrl_d.rst_en = ctrl_q.rst_en | wd[WTC_BIT_RST_EN];
			end
			if (wd[WTC_BIT_IRQ_FLAG]) begin
				ctrl_d.irq_flag = 1'b0;
			end
		end
		if (ack) begin
			ctrl_d.irq_flag = 1'b0;
			if (mode == WTC_MODE_IRQRST) begin
				ctrl_d.irq_en = 1'b0;
			end
		end
		if (set_flag) begin
			ctrl_d.irq_flag = 1'b1;
		end
		if (sys_rst_fire) begin
			ctrl_d = WTC_CTRL_RST;
		end
	end

	// Counter, watchdog reset flag and event status
	assign cnt_d = (restart | timeout | ~running | sys_rst_fire) ? '0 :
		tick ? cnt_q + 21'h000001 : cnt_q;
	assign wrf_d = sys_rst_fire | (wrf_q & ~(wr_cause & ~wd[WTC_BIT_WRF]));
	assign ev_set = {reject, sys_rst_fire, timeout};
	assign istat_d = ev_set | (istat_q & ~(wr_istat ? hwdata[WTC_EV_W-1:0] : '0));
	assign imask_d = wr_imask ? hwdata[WTC_EV_W-1:0] : imask_q;
	assign bus_d = rd_take ? WTC_BUS_RDWAIT : WTC_BUS_IDLE;

	// Bus slave state; reads take one wait state so a write just before lands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aph_q <= '0;
			bus_q <= WTC_BUS_IDLE;
			rd_ofs_q <= WTC_UNMAPPED_OFS;
			hreadyout_q <= 1'b1;
			hrdata_q <= 32'h00000000;
		end else begin
			aph_q <= hready ? aph_d : aph_q;
			bus_q <= bus_d;
			rd_ofs_q <= rd_take ? aph_d.ofs : rd_ofs_q;
			hreadyout_q <= ~rd_take;
			hrdata_q <= (bus_q == WTC_BUS_RDWAIT) ? rd_mux : hrdata_q;
		end
	end

	// Control, unlock window and status registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= WTC_CTRL_RST;
			unlock_cnt_q <= 3'h0;
			wrf_q <= 1'b0;
			istat_q <= '0;
			imask_q <= WTC_IMASK_RST;
		end else begin
			ctrl_q <= ctrl_d;
			unlock_cnt_q <= unlock_cnt_d;
			wrf_q <= wrf_d;
			istat_q <= istat_d;
			imask_q <= imask_d;
		end
	end

	// Oscillator synchroniser and time-out counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_s1_q <= 1'b0;
			osc_s2_q <= 1'b0;
			osc_s3_q <= 1'b0;
			cnt_q <= '0;
		end else begin
			osc_s1_q <= wdt_osc;
			osc_s2_q <= osc_s1_q;
			osc_s3_q <= osc_s2_q;
			cnt_q <= cnt_d;
		end
	end

	// Registered outputs toward the core and interrupt controller
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_q <= 1'b0;
			wdt_irq_q <= 1'b0;
			sys_reset_q <= 1'b0;
			vector_addr_q <= WTC_VEC_RESET;
		end else begin
			irq_q <= |(istat_d & imask_d);
			wdt_irq_q <= ctrl_d.irq_flag & ctrl_d.irq_en;
			sys_reset_q <= sys_rst_fire;
			if (sys_rst_fire) begin
				vector_addr_q <= WTC_VEC_RESET;
			end else if (set_flag) begin
				vector_addr_q <= 12'(WTC_VEC_WDT_IDX * WTC_VEC_WORDS);
			end
		end
	end

	// Ports driven straight from their flops; hresp is tied to OKAY
	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = 1'b0;
	assign irq = irq_q;
	assign wdt_irq_req = wdt_irq_q;
	assign sys_reset_req = sys_reset_q;
	assign vector_addr = vector_addr_q;

	// Checks on the watchdog behaviour
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_unlock_window: assert property ($rose(unlock) |-> unlock [*4])
		else $error("unlock window shorter than four cycles");

	a_unlock_closes: assert property ((unlock_cnt_q == 3'h1 && !open_seq) |=> !unlock)
		else $error("unlock bit did not clear");

	a_lock_holds_sel: assert property ((!unlock && !sys_rst_fire) |=> $stable(ctrl_q.sel))
		else $error("select changed while locked");

	a_lock_holds_en: assert property ((!unlock && ctrl_q.rst_en && !sys_rst_fire)
		|=> ctrl_q.rst_en)
		else $error("reset enable cleared while locked");

	a_wrf_forces_en: assert property (wrf_q |-> ctrl_rd[WTC_BIT_RST_EN] &&
		(!timeout || ctrl_q.irq_en || sys_rst_fire))
		else $error("reset enable not forced by reset flag");

	a_period_align: assert property (timeout |-> cnt_q[10:0] == 11'h7ff)
		else $error("time-out before 2048 cycle boundary");

	a_osc_only: assert property ((!tick && !restart) |=> $stable(cnt_q) || cnt_q == '0)
		else $error("counter moved without oscillator edge");

	a_reset_vector: assert property (sys_rst_fire |=> sys_reset_q && wrf_q &&
		vector_addr_q == 12'h000 ##1 !sys_reset_q)
		else $error("system reset not delivered via reset vector");

	a_irq_vector: assert property ((set_flag && !sys_rst_fire) |=>
		ctrl_q.irq_flag && vector_addr_q == 12'h006)
		else $error("time-out interrupt not on its vector");

	a_stopped_mode: assert property (mode == WTC_MODE_STOP |=> cnt_q == '0)
		else $error("counter running in stopped mode");

	a_flag_w1c: assert property ((wr_ctrl && wd[7] && !set_flag) |=> !ctrl_q.irq_flag)
		else $error("interrupt flag not cleared by write");

	a_combined_ack: assert property ((ack && mode == WTC_MODE_IRQRST && !wr_ctrl &&
		!set_flag && !sys_rst_fire) |=> !ctrl_q.irq_en && !ctrl_q.irq_flag)
		else $error("vector entry did not drop to reset mode");

	a_sel_clamp: assert property (ctrl_q.sel > 4'h9 |-> lim_m1 == 21'h0fffff)
		else $error("reserved select not clamped");

	a_restart_clears: assert property (restart |=> cnt_q == '0)
		else $error("restart did not clear counter");

	// Bus handshake: reads wait one cycle, writes none
	a_read_wait: assert property ((take && !hwrite) |=> !hreadyout ##1 hreadyout)
		else $error("read wait state not exactly one cycle");

	a_write_no_wait: assert property ((take && hwrite) |=> hreadyout)
		else $error("write inserted a wait state");

	// Output levels follow the registers that feed them
	a_irq_level: assert property (irq == |(istat_q & imask_q))
		else $error("interrupt line does not follow status and mask");

	a_req_level: assert property (wdt_irq_req ==
		(ctrl_q.irq_flag & ctrl_q.irq_en))
		else $error("time-out request does not follow flag and enable");

	// Unlock window and refused writes
	a_unlock_load: assert property (open_seq |=>
		unlock_cnt_q == WTC_UNLOCK_CYCLES)
		else $error("unlock window not loaded by opening write");

	a_reject_event: assert property (reject |=> istat_q[WTC_EV_REJECT])
		else $error("refused write not reported");

	// Period end points; the longest code is far too slow to run, so only its limit
	a_sel0_period: assert property ((tick && running && ctrl_q.sel == 4'h0 &&
		cnt_q == 21'h0007ff) |-> timeout)
		else $error("code zero did not time out at 2048 edges");

	a_sel9_limit: assert property (ctrl_q.sel == 4'h9 |-> lim_m1 == 21'h0fffff)
		else $error("code nine limit wrong");

	a_tick_single: assert property (tick |=> !tick)
		else $error("one oscillator edge counted twice");

	// Mode behaviour on a time-out
	a_stop_quiet: assert property (mode == WTC_MODE_STOP |->
		!timeout && !sys_rst_fire)
		else $error("stopped watchdog acted");

	a_rst_mode_resets: assert property ((timeout && mode == WTC_MODE_RST)
		|-> sys_rst_fire)
		else $error("reset mode time-out did not reset");

	a_combined_first: assert property ((timeout && mode == WTC_MODE_IRQRST &&
		!ctrl_q.irq_flag) |-> set_flag && !sys_rst_fire)
		else $error("combined mode first time-out did not interrupt");

	a_ack_clears_flag: assert property ((ack && !set_flag) |=> !ctrl_q.irq_flag)
		else $error("vector entry did not clear the flag");

	a_sysrst_clears: assert property (sys_rst_fire |=>
		ctrl_q == WTC_CTRL_RST && cnt_q == '0)
		else $error("system reset left control or counter set");

	// Reset flag is sticky until software writes zero to it
	a_wrf_sticky: assert property ((wrf_q && !wr_cause) |=> wrf_q)
		else $error("reset flag dropped on its own");

	a_wrf_clear: assert property ((wr_cause && !wd[WTC_BIT_WRF] && !sys_rst_fire)
		|=> !wrf_q)
		else $error("reset flag not cleared by write of zero");

endmodule

// >>> test/wtc_tb.sv
// Self-checking bench for the watchdog time-out control block
module testbench
	import wtc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk, hresetn, hsel, hwrite, wdt_osc, wdt_restart, vector_enter;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hready, hreadyout, hresp, irq, wdt_irq_req, sys_reset_req;
	logic [11:0] vector_addr;
	int errors = 0;
	int n_compared = 0;
	int n_rst = 0;

	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;

	wtc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .wdt_osc(wdt_osc), .wdt_restart(wdt_restart),
		.vector_enter(vector_enter), .irq(irq), .wdt_irq_req(wdt_irq_req),
		.sys_reset_req(sys_reset_req), .vector_addr(vector_addr));

	// 50 MHz system clock
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	// Counts system reset pulses; a level instead of a pulse shows as extra counts
	always @(posedge hclk) begin
		if (sys_reset_req === 1'b1)
			n_rst++;
	end

	task automatic results();
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One AHB-Lite single word transfer; caller stands just after a rising edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= WTC_HSIZE_WORD;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		bus(1'b1, a, d, dummy);
	endtask

	task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		bus(1'b0, a, 32'h00000000, v);
		chk(name, v, exp);
	endtask

	// Watchdog oscillator edges, slow enough for the two-flop synchroniser
	task automatic osc(input int n);
		repeat (n) begin
			wdt_osc <= 1'b1;
			repeat (2) @(posedge hclk);
			wdt_osc <= 1'b0;
			repeat (2) @(posedge hclk);
		end
		repeat (8) @(posedge hclk);
	endtask

	task automatic pulse_restart();
		wdt_restart <= 1'b1;
		@(posedge hclk);
		wdt_restart <= 1'b0;
	endtask

	task automatic pulse_vector();
		vector_enter <= 1'b1;
		@(posedge hclk);
		vector_enter <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask

	task automatic t_reset();
		rdchk("ctrl", WTC_CTRL_OFS, 32'h00000000);
		rdchk("cause", WTC_CAUSE_OFS, 32'h00000000);
		rdchk("mask", WTC_IMASK_OFS, 32'h00000000);
		rdchk("unmapped", WTC_UNMAPPED_OFS, 32'h00000000);
		chk("vector", {20'h00000, vector_addr}, 32'h00000000);
		chk("hresp", {31'h0, hresp}, 32'h00000000);
	endtask

	// Select change without unlock is refused and flagged as an interrupt event
	task automatic t_locked();
		wr(WTC_IMASK_OFS, 32'h00000004);
		wr(WTC_CTRL_OFS, 32'h00000005);
		rdchk("ctrl locked", WTC_CTRL_OFS, 32'h00000000);
		chk("irq set", {31'h0, irq}, 32'h00000001);
		wr(WTC_ISTAT_OFS, 32'h00000007);
		repeat (2) @(posedge hclk);
		chk("irq clr", {31'h0, irq}, 32'h00000000);
	endtask

	// Timed sequence: in time succeeds, late one is refused
	task automatic t_unlock();
		wr(WTC_CTRL_OFS, 32'h00000018);
		wr(WTC_CTRL_OFS, 32'h00000021);
		repeat (4) @(posedge hclk);
		rdchk("ctrl sel9", WTC_CTRL_OFS, 32'h00000021);
		wr(WTC_CTRL_OFS, 32'h00000018);
		repeat (4) @(posedge hclk);
		wr(WTC_CTRL_OFS, 32'h00000000);
		rdchk("ctrl late", WTC_CTRL_OFS, 32'h00000029);
		wr(WTC_CTRL_OFS, 32'h00000018);
		wr(WTC_CTRL_OFS, 32'h00000027);
		repeat (4) @(posedge hclk);
		rdchk("ctrl rsvd", WTC_CTRL_OFS, 32'h00000027);
		wr(WTC_CTRL_OFS, 32'h00000018);
		wr(WTC_CTRL_OFS, 32'h00000000);
		repeat (4) @(posedge hclk);
		rdchk("ctrl open", WTC_CTRL_OFS, 32'h00000000);
	endtask

	// Interrupt mode: restart holds off the time-out, exact edge count fires it
	task automatic t_irq_mode();
		wr(WTC_CTRL_OFS, 32'h00000040);
		pulse_restart();
		osc(2000);
		pulse_restart();
		osc(2047);
		chk("req early", {31'h0, wdt_irq_req}, 32'h00000000);
		osc(1);
		chk("req", {31'h0, wdt_irq_req}, 32'h00000001);
		chk("vector irq", {20'h00000, vector_addr}, 32'h00000006);
		rdchk("ctrl flag", WTC_CTRL_OFS, 32'h000000c0);
		pulse_vector();
		chk("req ack", {31'h0, wdt_irq_req}, 32'h00000000);
		rdchk("ctrl ack", WTC_CTRL_OFS, 32'h00000040);
		wr(WTC_CTRL_OFS, 32'h00000000);
	endtask

	// Combined mode falls into reset mode; reset flag then pins reset-enable
	task automatic t_combined();
		wr(WTC_CTRL_OFS, 32'h00000048);
		pulse_restart();
		osc(1000);
		wr(WTC_RESTART_OFS, 32'h00000000);
		osc(2047);
		chk("req early2", {31'h0, wdt_irq_req}, 32'h00000000);
		osc(1);
		chk("req comb", {31'h0, wdt_irq_req}, 32'h00000001);
		pulse_vector();
		rdchk("ctrl comb", WTC_CTRL_OFS, 32'h00000008);
		chk("no rst yet", n_rst, 32'h00000000);
		osc(2048);
		chk("rst pulses", n_rst, 32'h00000001);
		chk("vector rst", {20'h00000, vector_addr}, 32'h00000000);
		rdchk("istat", WTC_ISTAT_OFS, 32'h00000007);
		rdchk("cause", WTC_CAUSE_OFS, 32'h00000008);
		wr(WTC_CTRL_OFS, 32'h00000018);
		wr(WTC_CTRL_OFS, 32'h00000000);
		repeat (4) @(posedge hclk);
		rdchk("ctrl forced", WTC_CTRL_OFS, 32'h00000008);
		wr(WTC_CAUSE_OFS, 32'h00000000);
		wr(WTC_CTRL_OFS, 32'h00000018);
		wr(WTC_CTRL_OFS, 32'h00000000);
		repeat (4) @(posedge hclk);
		rdchk("ctrl off", WTC_CTRL_OFS, 32'h00000000);
	endtask

	// Main sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = WTC_HSIZE_WORD;
		hwdata = 32'h00000000;
		wdt_osc = 1'b0;
		wdt_restart = 1'b0;
		vector_enter = 1'b0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_locked();
		t_unlock();
		t_irq_mode();
		t_combined();
		results();
	end

	// Hang guard: the scenarios need about 40000 cycles
	initial begin
		#(60000 * 20);
		errors++;
		results();
	end
endmodule
